// ===== hw/pab_bridge.sv
`default_nettype none

module pab_bridge (
  input  wire logic        sys_clk,     // System clock
  input  wire logic        reset_n,     // Synchronous reset, active low
  input  wire logic        s_hsel,      // DMA AHB select
  input  wire logic [31:0] s_haddr,     // DMA AHB address
  input  wire logic [1:0]  s_htrans,    // DMA AHB transfer type
  input  wire logic        s_hwrite,    // DMA AHB write
  input  wire logic [31:0] s_hwdata,    // DMA AHB write data
  input  wire logic        s_hready,    // DMA AHB bus ready
  output logic             s_hreadyout, // Slave ready
  output logic [31:0]      s_hrdata,    // Read data
  output logic             s_hresp,     // Always OKAY
  output logic [31:0]      e_awaddr,    // Endpoint write address
  output logic [7:0]       e_awlen,     // Endpoint write length
  output logic [2:0]       e_awsize,    // Endpoint write size
  output logic [1:0]       e_awburst,   // Endpoint write burst
  output logic             e_awvalid,   // Write address valid
  input  wire logic        e_awready,   // Write address taken
  output logic [31:0]      e_wdata,     // Write beat data
  output logic [3:0]       e_wstrb,     // Write beat strobes
  output logic             e_wlast,     // Last write beat
  output logic             e_wvalid,    // Write beat valid
  input  wire logic        e_wready,    // Write beat taken
  input  wire logic        e_bvalid,    // Write response valid
  output logic             e_bready,    // Write response taken
  output logic [31:0]      e_araddr,    // Endpoint read address
  output logic [7:0]       e_arlen,     // Endpoint read length
  output logic [2:0]       e_arsize,    // Endpoint read size
  output logic [1:0]       e_arburst,   // Endpoint read burst
  output logic             e_arvalid,   // Read address valid
  input  wire logic        e_arready,   // Read address taken
  input  wire logic [31:0] e_rdata,     // Read beat data
  input  wire logic        e_rlast,     // Last read beat
  input  wire logic        e_rvalid,    // Read beat valid
  output logic             e_rready,    // Read beat taken
  input  wire logic [31:0] p_awaddr,    // Endpoint master write address
  input  wire logic [7:0]  p_awlen,     // Endpoint master write length
  input  wire logic        p_awvalid,   // Write address valid
  output logic             p_awready,   // Write address taken
  input  wire logic [31:0] p_wdata,     // Write data
  input  wire logic        p_wvalid,    // Write data valid
  output logic             p_wready,    // Write data taken
  output logic             p_bvalid,    // Write response valid
  input  wire logic        p_bready,    // Write response taken
  input  wire logic [31:0] p_araddr,    // Endpoint master read address
  input  wire logic [7:0]  p_arlen,     // Endpoint master read length
  input  wire logic        p_arvalid,   // Read address valid
  output logic             p_arready,   // Read address taken
  output logic [31:0]      p_rdata,     // Read data
  output logic             p_rlast,     // Last read beat
  output logic             p_rvalid,    // Read data valid
  input  wire logic        p_rready,    // Read data taken
  output logic [31:0]      f_haddr,     // SRAM AHB address
  output logic [1:0]       f_htrans,    // SRAM AHB transfer type
  output logic             f_hwrite,    // SRAM AHB write
  output logic [2:0]       f_hsize,     // SRAM AHB size
  output logic [31:0]      f_hwdata,    // SRAM AHB write data
  input  wire logic        f_hready,    // SRAM AHB ready
  input  wire logic [31:0] f_hrdata,    // SRAM AHB read data
  output logic [pab_pkg::LED_BITS-1:0] led,  // LED lines
  input  wire logic [pab_pkg::DIP_BITS-1:0] dip, // DIP switch lines
  output logic [3:0]       link_lanes,  // Configured lane count
  output logic [1:0]       link_gen     // Configured rate generation
);

  // ****************************************
  // Outbound buffering bridge
  // ****************************************
  typedef enum logic [2:0] {B_IDLE, B_WDAT, B_AW, B_W, B_B, B_RCHK, B_AR, B_R} pab_brg_e;

  pab_brg_e    bs_q, bs_d;
  logic [31:0] wbuf_q [pab_pkg::LINE_WORDS];
  logic [31:0] wbuf_d [pab_pkg::LINE_WORDS];
  logic [31:0] rbuf_q [pab_pkg::LINE_WORDS];
  logic [31:0] rbuf_d [pab_pkg::LINE_WORDS];
  logic [7:0]  wmask_q, wmask_d;
  logic [26:0] line_q, line_d, wline_q, wline_d, rline_q, rline_d;
  logic [2:0]  idx_q, idx_d, beat_q, beat_d;
  logic        rok_q, rok_d, pend_q, pend_d, hrdy_q, hrdy_d, uarv_q, uarv_d;
  logic        awv_q, awv_d, wv_q, wv_d, br_q, br_d;
  logic [31:0] hrd_q, hrd_d, awa_q, awa_d, uara_q, uara_d;
  logic        u_arready, u_rvalid, u_rlast;
  logic [31:0] u_rdata;
  logic [2:0]  size_q;
  logic [1:0]  burst_q;

  // Local line address to host address
  function automatic logic [31:0] host_map(input logic [31:0] a);
    host_map = pab_pkg::SWIN0_HOST_BASE | (a & pab_pkg::SWIN0_MASK);
  endfunction

  assign s_hreadyout = hrdy_q;
  assign s_hrdata    = hrd_q;
  assign s_hresp     = 1'b0;                 // Every transfer answers OKAY
  assign e_awaddr    = awa_q;
  assign e_awlen     = pab_pkg::LINE_LEN;
  assign e_awsize    = size_q;
  assign e_awburst   = burst_q;
  assign e_arsize    = size_q;
  assign e_arburst   = burst_q;
  assign e_awvalid   = awv_q;
  assign e_wvalid    = wv_q;
  assign e_bready    = br_q;
  assign e_wdata     = wbuf_q[beat_q];
  assign e_wstrb     = {4{wmask_q[beat_q]}};
  assign e_wlast     = (beat_q == pab_pkg::LAST_IDX);

  // Collect writes, fetch reads, drive the endpoint bursts
  always_comb begin
    bs_d = bs_q;   wbuf_d = wbuf_q;   rbuf_d = rbuf_q;   wmask_d = wmask_q;
    line_d = line_q;   wline_d = wline_q;   rline_d = rline_q;   idx_d = idx_q;
    beat_d = beat_q;   rok_d = rok_q;   pend_d = pend_q;   hrdy_d = hrdy_q;
    uarv_d = uarv_q;   awv_d = awv_q;   wv_d = wv_q;   br_d = br_q;
    hrd_d = hrd_q;   awa_d = awa_q;   uara_d = uara_q;
    case (bs_q)
      B_IDLE: begin
        if (s_hsel && s_htrans[1] && s_hready) begin
          idx_d  = s_haddr[pab_pkg::LINE_LSB-1:pab_pkg::IDX_LSB];
          line_d = s_haddr[31:pab_pkg::LINE_LSB];
          hrdy_d = 1'b0;
          bs_d   = s_hwrite ? B_WDAT : B_RCHK;
        end
      end
      B_WDAT: begin
        rok_d = 1'b0;
        if (wmask_q != 8'h00 && line_q != wline_q) begin
          pend_d = 1'b1;
          awa_d  = host_map({wline_q, 5'h00});
          awv_d  = 1'b1;
          bs_d   = B_AW;
        end else begin
          wbuf_d[idx_q]  = s_hwdata;
          wmask_d[idx_q] = 1'b1;
          wline_d        = line_q;
          pend_d         = 1'b0;
          if (idx_q == pab_pkg::LAST_IDX) begin
            awa_d = host_map({line_q, 5'h00});
            awv_d = 1'b1;
            bs_d  = B_AW;
          end else begin
            hrdy_d = 1'b1;
            bs_d   = B_IDLE;
          end
        end
      end
      B_AW: begin
        if (e_awready) begin
          awv_d  = 1'b0;
          wv_d   = 1'b1;
          beat_d = 3'h0;
          bs_d   = B_W;
        end
      end
      B_W: begin
        if (e_wready) begin
          if (beat_q == pab_pkg::LAST_IDX) begin
            wv_d = 1'b0;
            br_d = 1'b1;
            bs_d = B_B;
          end else begin
            beat_d = beat_q + 3'h1;
          end
        end
      end
      B_B: begin
        if (e_bvalid) begin
          br_d    = 1'b0;
          wmask_d = 8'h00;
          if (pend_q) begin
            bs_d = B_WDAT;
          end else begin
            hrdy_d = 1'b1;
            bs_d   = B_IDLE;
          end
        end
      end
      B_RCHK: begin
        if (rok_q && rline_q == line_q) begin
          hrd_d  = rbuf_q[idx_q];
          hrdy_d = 1'b1;
          bs_d   = B_IDLE;
        end else begin
          uara_d = host_map({line_q, idx_q, 2'h0});
          uarv_d = 1'b1;
          bs_d   = B_AR;
        end
      end
      B_AR: begin
        if (u_arready) begin
          uarv_d = 1'b0;
          beat_d = idx_q;
          bs_d   = B_R;
        end
      end
      B_R: begin
        if (u_rvalid) begin
          rbuf_d[beat_q] = u_rdata;
          beat_d         = beat_q + 3'h1;
          if (u_rlast) begin
            hrd_d   = (beat_q == idx_q) ? u_rdata : rbuf_q[idx_q];
            rok_d   = 1'b1;
            rline_d = line_q;
            hrdy_d  = 1'b1;
            bs_d    = B_IDLE;
          end
        end
      end
      default: bs_d = B_IDLE;
    endcase
  end

  // Bridge registers, all on the one system clock
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bs_q <= B_IDLE;   wmask_q <= 8'h00;   line_q <= '0;   wline_q <= '0;
      rline_q <= '0;   idx_q <= 3'h0;   beat_q <= 3'h0;   rok_q <= 1'b0;
      pend_q <= 1'b0;   hrdy_q <= 1'b1;   uarv_q <= 1'b0;   awv_q <= 1'b0;
      wv_q <= 1'b0;   br_q <= 1'b0;   hrd_q <= 32'h0000_0000;
      awa_q <= 32'h0000_0000;   uara_q <= 32'h0000_0000;
      wbuf_q <= '{default: 32'h0000_0000};
      rbuf_q <= '{default: 32'h0000_0000};
    end else begin
      bs_q <= bs_d;   wmask_q <= wmask_d;   line_q <= line_d;   wline_q <= wline_d;
      rline_q <= rline_d;   idx_q <= idx_d;   beat_q <= beat_d;   rok_q <= rok_d;
      pend_q <= pend_d;   hrdy_q <= hrdy_d;   uarv_q <= uarv_d;   awv_q <= awv_d;
      wv_q <= wv_d;   br_q <= br_d;   hrd_q <= hrd_d;   awa_q <= awa_d;
      uara_q <= uara_d;   wbuf_q <= wbuf_d;   rbuf_q <= rbuf_d;
    end
  end

  // Wrap to incrementing read conversion
  pab_wrap_conv u_conv (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .u_araddr  (uara_q),
    .u_arburst (pab_pkg::BURST_WRAP),
    .u_arvalid (uarv_q),
    .u_arready (u_arready),
    .u_rvalid  (u_rvalid),
    .u_rdata   (u_rdata),
    .u_rlast   (u_rlast),
    .m_araddr  (e_araddr),
    .m_arlen   (e_arlen),
    .m_arvalid (e_arvalid),
    .m_arready (e_arready),
    .m_rvalid  (e_rvalid),
    .m_rdata   (e_rdata),
    .m_rlast   (e_rlast),
    .m_rready  (e_rready)
  );

  // ****************************************
  // Inbound master path and GPIO
  // ****************************************
  typedef enum logic [2:0] {M_IDLE, M_WAIT, M_ISSUE, M_HA, M_HD, M_RESP, M_B, M_R} pab_mst_e;

  pab_mst_e    ms_q, ms_d;
  logic [31:0] ma_q, ma_d, wd_q, wd_d, rd_q, rd_d, fa_q, fa_d;
  logic [7:0]  ml_q, ml_d;
  logic        mw_q, mw_d, ardy_q, ardy_d, wr_q, wr_d, bv_q, bv_d, rv_q, rv_d;
  logic        rl_q, rl_d, fw_q, fw_d;
  logic [1:0]  ft_q, ft_d;
  logic [pab_pkg::LED_BITS-1:0] led_q, led_d;
  logic [pab_pkg::DIP_BITS-1:0] dip1_q, dip2_q, dip3_q, dip_q;
  logic [3:0]  lanes_q;
  logic [1:0]  gen_q;

  assign p_awready  = ardy_q;
  assign p_arready  = ardy_q;
  assign p_wready   = wr_q;
  assign p_bvalid   = bv_q;
  assign p_rvalid   = rv_q;
  assign p_rdata    = rd_q;
  assign p_rlast    = rl_q;
  assign f_haddr    = fa_q;
  assign f_htrans   = ft_q;
  assign f_hwrite   = fw_q;
  assign f_hsize    = size_q;
  assign f_hwdata   = wd_q;
  assign led        = led_q;
  assign link_lanes = lanes_q;
  assign link_gen   = gen_q;

  // Endpoint master beats to single AHB or GPIO accesses
  always_comb begin
    ms_d = ms_q;   ma_d = ma_q;   wd_d = wd_q;   rd_d = rd_q;   fa_d = fa_q;
    ml_d = ml_q;   mw_d = mw_q;   ardy_d = ardy_q;   wr_d = wr_q;   bv_d = bv_q;
    rv_d = rv_q;   rl_d = rl_q;   fw_d = fw_q;   ft_d = ft_q;   led_d = led_q;
    case (ms_q)
      M_IDLE: begin
        if (p_awvalid) begin
          ma_d = p_awaddr;   ml_d = p_awlen;   mw_d = 1'b1;
          ardy_d = 1'b0;   wr_d = 1'b1;   ms_d = M_WAIT;
        end else if (p_arvalid) begin
          ma_d = p_araddr;   ml_d = p_arlen;   mw_d = 1'b0;
          ardy_d = 1'b0;   ms_d = M_ISSUE;
        end
      end
      M_WAIT: begin
        if (p_wvalid) begin
          wd_d = p_wdata;   wr_d = 1'b0;   ms_d = M_ISSUE;
        end
      end
      M_ISSUE: begin
        if (ma_q[pab_pkg::MWIN_SEL_BIT]) begin
          fa_d = pab_pkg::MWIN1_SRAM_BASE | (ma_q & pab_pkg::MWIN_OFS_MASK);
          ft_d = pab_pkg::HTRANS_NSEQ;
          fw_d = mw_q;
          ms_d = M_HA;
        end else begin
          if ((ma_q & pab_pkg::MWIN_OFS_MASK) == pab_pkg::GPIO_IN_OFS) begin
            rd_d = 32'(dip_q);
          end else begin
            rd_d = 32'(led_q);
            if (mw_q) led_d = wd_q[pab_pkg::LED_BITS-1:0];
          end
          ms_d = M_RESP;
        end
      end
      M_HA: begin
        if (f_hready) begin
          ft_d = pab_pkg::HTRANS_IDLE;
          ms_d = M_HD;
        end
      end
      M_HD: begin
        if (f_hready) begin
          rd_d = f_hrdata;
          ms_d = M_RESP;
        end
      end
      M_RESP: begin
        if (mw_q && ml_q == 8'h00) begin
          bv_d = 1'b1;   ms_d = M_B;
        end else if (mw_q) begin
          ml_d = ml_q - 8'h01;   ma_d = ma_q + pab_pkg::WORD_STEP;
          wr_d = 1'b1;   ms_d = M_WAIT;
        end else begin
          rv_d = 1'b1;   rl_d = (ml_q == 8'h00);   ms_d = M_R;
        end
      end
      M_B: begin
        if (p_bready) begin
          bv_d = 1'b0;   ardy_d = 1'b1;   ms_d = M_IDLE;
        end
      end
      M_R: begin
        if (p_rready) begin
          rv_d = 1'b0;
          if (rl_q) begin
            ardy_d = 1'b1;   ms_d = M_IDLE;
          end else begin
            ml_d = ml_q - 8'h01;   ma_d = ma_q + pab_pkg::WORD_STEP;   ms_d = M_ISSUE;
          end
        end
      end
      default: ms_d = M_IDLE;
    endcase
  end

  // Master path, GPIO, DIP sampling and fixed link setup
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ms_q <= M_IDLE;   ma_q <= 32'h0000_0000;   wd_q <= 32'h0000_0000;
      rd_q <= 32'h0000_0000;   fa_q <= 32'h0000_0000;   ml_q <= 8'h00;
      mw_q <= 1'b0;   ardy_q <= 1'b1;   wr_q <= 1'b0;   bv_q <= 1'b0;
      rv_q <= 1'b0;   rl_q <= 1'b0;   fw_q <= 1'b0;   ft_q <= pab_pkg::HTRANS_IDLE;
      led_q <= '0;   dip1_q <= '0;   dip2_q <= '0;   dip3_q <= '0;   dip_q <= '0;
      size_q <= pab_pkg::SIZE_WORD;   burst_q <= pab_pkg::BURST_INCR;
      lanes_q <= 4'h0;   gen_q <= 2'h0;
    end else begin
      ms_q <= ms_d;   ma_q <= ma_d;   wd_q <= wd_d;   rd_q <= rd_d;   fa_q <= fa_d;
      ml_q <= ml_d;   mw_q <= mw_d;   ardy_q <= ardy_d;   wr_q <= wr_d;   bv_q <= bv_d;
      rv_q <= rv_d;   rl_q <= rl_d;   fw_q <= fw_d;   ft_q <= ft_d;   led_q <= led_d;
      dip1_q <= dip;   dip2_q <= dip1_q;   dip3_q <= dip2_q;
      dip_q <= (dip2_q & dip3_q) | (dip_q & (dip2_q ^ dip3_q));
      lanes_q <= pab_pkg::LINK_LANES;
      gen_q <= pab_pkg::LINK_GEN;
    end
  end

endmodule

`default_nettype wire

// ===== hw/pab_hresp_note.sv
`default_nettype none
`default_nettype wire

// ===== hw/pab_wrap_conv.sv
`default_nettype none

module pab_wrap_conv (
  input  wire logic        sys_clk,     // System clock
  input  wire logic        reset_n,     // Synchronous reset, active low
  input  wire logic [31:0] u_araddr,    // Requested read address
  input  wire logic [1:0]  u_arburst,   // Requested burst type
  input  wire logic        u_arvalid,   // Read request valid
  output logic             u_arready,   // Read request taken
  output logic             u_rvalid,    // Returned beat valid
  output logic [31:0]      u_rdata,     // Returned beat data
  output logic             u_rlast,     // Final beat of whole line
  output logic [31:0]      m_araddr,    // Endpoint read address
  output logic [7:0]       m_arlen,     // Endpoint burst length
  output logic             m_arvalid,   // Endpoint request valid
  input  wire logic        m_arready,   // Endpoint request taken
  input  wire logic        m_rvalid,    // Endpoint beat valid
  input  wire logic [31:0] m_rdata,     // Endpoint beat data
  input  wire logic        m_rlast,     // Endpoint burst end
  output logic             m_rready     // Beat accepted
);

  typedef enum logic [1:0] {C_IDLE, C_AR, C_R} pab_conv_e;

  pab_conv_e   st_q, st_d;
  logic [31:0] addr_q, addr_d, base_q, base_d;
  logic [7:0]  len_q, len_d, len2_q, len2_d;
  logic        two_q, two_d, arv_q, arv_d, rdy_q, rdy_d;
  logic [2:0]  off;

  // ****************************************
  // Beat path back to the requester
  // ****************************************
  assign u_arready = (st_q == C_IDLE);
  assign u_rvalid  = m_rvalid & rdy_q;
  assign u_rdata   = m_rdata;
  assign u_rlast   = m_rlast & ~two_q;
  assign m_araddr  = addr_q;
  assign m_arlen   = len_q;
  assign m_arvalid = arv_q;
  assign m_rready  = rdy_q;
  assign off       = u_araddr[pab_pkg::LINE_LSB-1:pab_pkg::IDX_LSB];

  // Split a wrap into tail then head, both incrementing
  always_comb begin
    st_d   = st_q;
    addr_d = addr_q;
    base_d = base_q;
    len_d  = len_q;
    len2_d = len2_q;
    two_d  = two_q;
    arv_d  = arv_q;
    rdy_d  = rdy_q;
    case (st_q)
      C_IDLE: begin
        if (u_arvalid) begin
          addr_d = u_araddr;
          base_d = {u_araddr[31:pab_pkg::LINE_LSB], 5'h00};
          if (u_arburst == pab_pkg::BURST_WRAP && off != 3'h0) begin
            len_d  = pab_pkg::LINE_LEN - 8'(off);
            len2_d = 8'(off) - 8'h01;
            two_d  = 1'b1;
          end else begin
            len_d = pab_pkg::LINE_LEN;
            two_d = 1'b0;
          end
          arv_d = 1'b1;
          st_d  = C_AR;
        end
      end
      C_AR: begin
        if (m_arready) begin
          arv_d = 1'b0;
          rdy_d = 1'b1;
          st_d  = C_R;
        end
      end
      C_R: begin
        if (m_rvalid && m_rlast) begin
          rdy_d = 1'b0;
          if (two_q) begin
            addr_d = base_q;
            len_d  = len2_q;
            two_d  = 1'b0;
            arv_d  = 1'b1;
            st_d   = C_AR;
          end else begin
            st_d = C_IDLE;
          end
        end
      end
      default: st_d = C_IDLE;
    endcase
  end

  // Converter state
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_q   <= C_IDLE;
      addr_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
      len_q  <= 8'h00;
      len2_q <= 8'h00;
      two_q  <= 1'b0;
      arv_q  <= 1'b0;
      rdy_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      addr_q <= addr_d;
      base_q <= base_d;
      len_q  <= len_d;
      len2_q <= len2_d;
      two_q  <= two_d;
      arv_q  <= arv_d;
      rdy_q  <= rdy_d;
    end
  end

endmodule

`default_nettype wire

// ===== shared/pab_pkg.sv
`default_nettype none

package pab_pkg;

  // ****************************************
  // Line and word geometry
  // ****************************************
  localparam int unsigned LINE_BYTES = 32;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned LINE_WORDS = LINE_BYTES / WORD_BYTES;
  localparam logic [7:0]  LINE_LEN   = 8'(LINE_WORDS - 1);     // AXI len of one line
  localparam logic [2:0]  LAST_IDX   = 3'(LINE_WORDS - 1);
  localparam int unsigned IDX_LSB    = 2;                      // Word index field
  localparam int unsigned LINE_LSB   = 5;                      // Line address field

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [1:0] BURST_INCR   = 2'h1;
  localparam logic [1:0] BURST_WRAP   = 2'h2;
  localparam logic [2:0] SIZE_WORD    = 3'h2;                  // AXI size and HSIZE alike
  localparam logic [1:0] HTRANS_IDLE  = 2'h0;
  localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
  localparam logic [31:0] WORD_STEP   = 32'h0000_0004;

  // ****************************************
  // Address windows
  // ****************************************
  localparam logic [31:0] SWIN0_HOST_BASE = 32'h8000_0000;     // Outbound host base
  localparam logic [31:0] SWIN0_MASK      = 32'h0fff_ffff;
  localparam int unsigned MWIN_SEL_BIT    = 28;                // Set selects window 1
  localparam logic [31:0] MWIN0_GPIO_BASE = 32'h4001_3000;
  localparam logic [31:0] MWIN1_SRAM_BASE = 32'h2000_0000;
  localparam logic [31:0] MWIN_OFS_MASK   = 32'h0000_ffff;
  localparam logic [31:0] GPIO_IN_OFS     = 32'h0000_0004;     // Other offsets hit LEDs

  // ****************************************
  // GPIO and link configuration
  // ****************************************
  localparam int unsigned LED_BITS   = 8;
  localparam int unsigned DIP_BITS   = 4;
  localparam logic [3:0]  LINK_LANES = 4'h4;
  localparam logic [1:0]  LINK_GEN   = 2'h2;

endpackage

`default_nettype wire

// ===== verif/pab_bridge_tb.sv
`default_nettype none
module pab_bridge_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, s_hsel, s_hwrite, s_hready, s_hreadyout, s_hresp, e_awvalid, e_awready, e_wlast, e_wvalid;
  logic e_wready, e_bvalid, e_bready, e_arvalid, e_arready, e_rlast, e_rvalid, e_rready, p_awvalid, p_awready, ta;
  logic p_wvalid, p_wready, p_bvalid, p_bready, p_arvalid, p_arready, p_rlast, p_rvalid, p_rready, f_hwrite, f_hready;
  logic [31:0] s_haddr, s_hwdata, s_hrdata, e_awaddr, e_wdata, e_araddr, e_rdata, p_awaddr, p_wdata, p_araddr, q;
  logic [31:0] p_rdata, f_haddr, f_hwdata, f_hrdata;
  logic [7:0]  e_awlen, e_arlen, p_awlen, p_arlen, led;
  logic [3:0]  e_wstrb, dip, link_lanes;
  logic [2:0]  e_awsize, e_arsize, f_hsize;
  logic [1:0]  s_htrans, e_awburst, e_arburst, f_htrans, link_gen;
  logic        slow, tw, tr, tb;
  int          bad_count, num_checks, n, i;
  logic [31:0] rows [5][2] = '{'{32'h0000_0100, 32'h8000_0100}, '{32'h0000_012c, 32'h8000_012c},
                               '{32'h0000_015c, 32'h8000_015c}, '{32'h1234_5664, 32'h8234_5664},
                               '{32'h1234_5670, 32'h8234_5670}};
  pab_bridge dut (.*);
  pab_ep_model ep (.*);
  assign s_hready = s_hreadyout;
  task chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task ahb(input logic wr, input logic [31:0] a, d);
    @(negedge sys_clk);
    {s_hsel, s_htrans, s_hwrite, s_haddr} = {1'b1, pab_pkg::HTRANS_NSEQ, wr, a};
    @(negedge sys_clk);
    {s_htrans, s_hwdata} = {pab_pkg::HTRANS_IDLE, d};
    n = 0;
    do @(negedge sys_clk); while (s_hreadyout !== 1'b1 && ++n < 300);
    if (n >= 300) bad_count++;
  endtask
  task pxfer(input logic wr, input logic [31:0] a, d);
    @(negedge sys_clk);
    {p_awvalid, p_wvalid, p_bready, p_arvalid, p_rready, p_awaddr, p_araddr, p_wdata} = {wr, wr, wr, !wr, !wr, a, a, d};
    for (n = 0; n < 100 && (p_awvalid | p_arvalid | p_wvalid | p_bready | p_rready); n++) begin
      {ta, tw, tr, tb, q} = {p_awready, p_wready, p_rvalid, p_bvalid, p_rdata}; // Flop outputs, stand to the edge
      @(negedge sys_clk);
      if (ta) {p_awvalid, p_arvalid} = 2'h0;
      if (tw) p_wvalid = 0;
      if (tr) p_rready = 0;
      if (tb) p_bready = 0;
    end
    if (n >= 100) bad_count++;
  endtask
  // Clock
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Watchdog
  initial begin
    #50000;
    bad_count++;
    summarize;
  end
  // Line reads, line write, master path, second reset
  initial begin
    {reset_n, s_hsel, s_hwrite, s_htrans, s_haddr, s_hwdata, slow, p_awlen, p_arlen} = '0;
    {p_awvalid, p_wvalid, p_bready, p_arvalid, p_rready, p_awaddr, p_araddr, p_wdata} = '0;
    {f_hready, f_hrdata, dip} = {1'b1, 32'h5a5a_0f0f, 4'h9};
    repeat (3) @(negedge sys_clk);
    reset_n = 1;
    for (i = 0; i < 5; i++) begin
      ahb(0, rows[i][0], 0);
      chk(s_hrdata, rows[i][1]);
    end
    slow = 1;
    for (i = 0; i < 8; i++)
      ahb(1, 32'h0000_0200 + 4 * i, 32'h1000_0000 + i);
    for (i = 0; i < 8; i++)
      chk(ep.mem[8'h80 + i], 32'h1000_0000 + i);
    ahb(1, 32'h0000_0300, 32'h0000_00aa);
    ahb(1, 32'h0000_0320, 32'h0000_00bb);
    chk(ep.mem[8'hc0], 32'h0000_00aa);
    pxfer(1, 32'h0000_0000, 32'h0000_00a5);
    chk(led, 8'ha5);
    pxfer(0, 32'h0000_0004, 0);
    chk(q, {28'h0, dip});
    pxfer(0, 32'h1000_0040, 0);
    chk(q, f_hrdata);
    chk(f_haddr, 32'h2000_0040);
    chk(p_rlast, 1);
    pxfer(1, 32'h1000_0044, 32'h0000_c3c3);
    chk(f_hwdata, 32'h0000_c3c3);
    chk(f_haddr, 32'h2000_0044);
    chk(f_hwrite, 1);
    reset_n = 0;
    @(negedge sys_clk);
    chk(led, 0);
    reset_n = 1;
    ahb(0, 32'h0000_0180, 0);
    chk(s_hrdata, 32'h8000_0180);
    chk(s_hresp, 0);
    summarize;
  end
endmodule
`default_nettype wire

// ===== verif/pab_chk.sv
`default_nettype none
module pab_chk (
  input wire logic        sys_clk, reset_n, s_hsel, s_hready, s_hreadyout, e_awvalid, e_awready, // Controls
  input wire logic        e_arvalid, e_bready, f_hready,                                   // Controls
  input wire logic [1:0]  s_htrans, e_awburst, e_arburst, f_htrans, link_gen,              // Codes
  input wire logic [7:0]  e_awlen, e_arlen,                                                // Lengths
  input wire logic [3:0]  link_lanes,                                                      // Lanes
  input wire logic [31:0] e_awaddr, f_haddr                                                // Addresses
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // Bridge checks
  // ****
  a_link_setup: assert property ($past(reset_n) |-> link_lanes == 4'h4 && link_gen == 2'h2)
    else $error("link setup");
  a_aw_line: assert property (e_awvalid |-> e_awlen == 8'h07 && e_awburst == pab_pkg::BURST_INCR)
    else $error("write burst");
  a_host_map: assert property (e_awvalid |-> e_awaddr[31:28] == 4'h8 && e_awaddr[4:0] == 5'h00)
    else $error("host address");
  a_ar_incr: assert property (e_arvalid |-> e_arburst == pab_pkg::BURST_INCR && e_arlen <= 8'h07)
    else $error("read burst");
  a_aw_hold: assert property (e_awvalid && !e_awready |=> e_awvalid && $stable(e_awaddr))
    else $error("aw dropped");
  a_take_stall: assert property (s_hsel && s_htrans[1] && s_hready && s_hreadyout |=> !s_hreadyout)
    else $error("no stall");
  a_ahb_single: assert property (f_htrans == pab_pkg::HTRANS_NSEQ && f_hready |=> f_htrans == 2'h0)
    else $error("ahb single");
  a_sram_win: assert property (f_htrans == pab_pkg::HTRANS_NSEQ |-> f_haddr[31:16] == 16'h2000)
    else $error("sram window");
  a_b_taken: assert property (e_awvalid && e_awready |-> ##[1:60] e_bready)
    else $error("no response");
endmodule
bind pab_bridge pab_chk u_chk (.*);
`default_nettype wire

// ===== verif/pab_ep_model.sv
`default_nettype none
module pab_ep_model (
  input wire logic        sys_clk, reset_n, slow, e_awvalid, e_wvalid, e_wlast, e_bready, e_arvalid, e_rready, // Controls
  input wire logic [31:0] e_awaddr, e_wdata, e_araddr,                            // Addresses, data
  input wire logic [7:0]  e_arlen,                                                // Read length
  output logic            e_awready, e_wready, e_bvalid, e_arready, e_rvalid, e_rlast, // Answers
  output logic [31:0]     e_rdata                                                 // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wb, tick;
  logic [31:0] wa, mem [256];
  logic [7:0]  rl;
  // Write side stalls every other cycle when slow
  assign e_awready = !wb && !e_bvalid && (!slow || tick);
  assign e_wready = wb && (!slow || tick);
  assign e_arready = !e_rvalid;
  // Beat data is its own address; released data is inverted
  always @(posedge sys_clk) begin
    tick <= !tick && reset_n;
    if (!reset_n) begin
      {wb, e_bvalid, e_rvalid} <= '0;
    end else begin
      if (e_arvalid && e_arready)
        {e_rvalid, e_rdata, rl, e_rlast} <= {1'b1, e_araddr, e_arlen, e_arlen == 8'h00};
      else if (e_rvalid && e_rready)
        {e_rvalid, e_rdata, rl, e_rlast} <= {!e_rlast, e_rlast ? ~e_rdata : e_rdata + 32'h4, rl - 8'h1, rl == 8'h01};
      if (e_awvalid && e_awready)
        {wb, wa} <= {1'b1, e_awaddr};
      if (e_wvalid && e_wready) begin
        mem[wa[9:2]] <= e_wdata;
        wa <= wa + 32'h4;
        wb <= !e_wlast;
      end
      e_bvalid <= (e_wvalid && e_wready && e_wlast) || (e_bvalid && !e_bready);
    end
  end
endmodule
`default_nettype wire
